/* inc/pll_lock_defines.vh */
// constants for the pll lock detect and holdover block
`ifndef PLL_LOCK_DEFINES_VH
`define PLL_LOCK_DEFINES_VH

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define LOCK_CNT_W        14
`define PHASE_W           12
`define DAC_W             10
`define HOLD_MODE_W       2
`define HOLD_MODE_ENABLED 2'h2
`define DAC_MIDSCALE      10'h200
`define DAC_RESET         10'h200
`define LOCK_CNT_ZERO     14'h0000
`define LOCK_CNT_ONE      14'h0001

// ------------------------------------------------------------
// state codes
// ------------------------------------------------------------
`define ST_ACQUIRE        2'h0
`define ST_LOCKED         2'h1
`define ST_HOLDOVER       2'h2

`endif

/* rtl/phase_window_check.v */
// single comparison of phase error magnitude against the window
`default_nettype none

module phase_window_check #(
	parameter PHASE_W = 12
) (
	input  wire               core_clk,
	input  wire               rst,
	input  wire               sampleValid,
	input  wire [PHASE_W-1:0] phaseError,
	input  wire [PHASE_W-1:0] windowSize,
	output reg                checkValid,
	output reg                inWindow
);

	// ------------------------------------------------------------
	// two's complement magnitude
	// ------------------------------------------------------------
	wire               errNeg;
	wire [PHASE_W-1:0] errMag;

	assign errNeg = phaseError[PHASE_W-1];
	assign errMag = errNeg ? (~phaseError + {{(PHASE_W-1){1'b0}}, 1'b1}) : phaseError;

	// ------------------------------------------------------------
	// registered compare
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			checkValid <= 1'b0;
			inWindow   <= 1'b0;
		end else begin
			checkValid <= sampleValid;
			inWindow   <= (errMag <= windowSize);
		end
	end

endmodule

`default_nettype wire

/* rtl/pll_lock_detect_holdover.v */
// lock detector and holdover control for the first loop
`default_nettype none
`include "pll_lock_defines.vh"

// Overview of operation
// - lock time is counted in phase-detector comparisons up to the programmed count
// - lock indication rises after the programmed number of in-window comparisons
// - lock indication falls on any out-of-window comparison
// - with lockloss holdover disable low, loss of lock enters holdover
// - valid reference returning exits holdover and restarts lock acquisition
// - holdover is enabled only when holdover mode equals two
// - tracking enable low stops tuning voltage tracking into the dac
// - manual dac enable high drives holdover voltage from manual dac value
// - manual code 512 gives about half supply tuning voltage
module pll_lock_detect_holdover #(
	parameter LOCK_CNT_W = `LOCK_CNT_W,
	parameter PHASE_W    = `PHASE_W,
	parameter DAC_W      = `DAC_W
) (
	input  wire                  core_clk,
	input  wire                  rst,
	input  wire                  compareStrobe,
	input  wire [PHASE_W-1:0]    phaseError,
	input  wire [PHASE_W-1:0]    phase_window_size,
	input  wire [LOCK_CNT_W-1:0] lock_count_target,
	input  wire [`HOLD_MODE_W-1:0] holdoverMode,
	input  wire                  lockloss_holdover_disable,
	input  wire                  trackEnable,
	input  wire                  manual_dac_enable,
	input  wire [DAC_W-1:0]      manual_dac_value,
	input  wire [DAC_W-1:0]      tuneVoltageCode,
	input  wire                  referenceValid,
	output reg                   lock_indication,
	output reg                   holdoverActive,
	output reg                   tuneHold,
	output reg  [DAC_W-1:0]      holdoverDacCode,
	output reg  [LOCK_CNT_W-1:0] lockCount
);

	// ------------------------------------------------------------
	// state codes
	// ------------------------------------------------------------
	localparam [1:0] ST_ACQUIRE  = `ST_ACQUIRE;
	localparam [1:0] ST_LOCKED   = `ST_LOCKED;
	localparam [1:0] ST_HOLDOVER = `ST_HOLDOVER;

	// ------------------------------------------------------------
	// window comparison
	// ------------------------------------------------------------
	wire checkValid;
	wire inWindow;

	phase_window_check #(
		.PHASE_W(PHASE_W)
	) u_check (
		.core_clk   (core_clk),
		.rst        (rst),
		.sampleValid(compareStrobe),
		.phaseError (phaseError),
		.windowSize (phase_window_size),
		.checkValid (checkValid),
		.inWindow   (inWindow)
	);

	// ------------------------------------------------------------
	// lock counter and lock indication
	// ------------------------------------------------------------
	reg [LOCK_CNT_W-1:0] next_lockCount;
	reg                  next_lock;
	wire                 countReached;

	assign countReached = (lockCount >= lock_count_target);

	always @* begin
		next_lockCount = lockCount;
		next_lock      = lock_indication;
		if (holdoverActive) begin
			next_lockCount = `LOCK_CNT_ZERO;
			next_lock      = 1'b0;
		end else if (checkValid) begin
			if (!inWindow) begin
				next_lockCount = `LOCK_CNT_ZERO;
				next_lock      = 1'b0;
			end else begin
				if (!countReached)
					next_lockCount = lockCount + `LOCK_CNT_ONE;
				if ((lockCount + `LOCK_CNT_ONE) >= lock_count_target)
					next_lock = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// holdover state machine
	// ------------------------------------------------------------
	reg [1:0] state;
	reg [1:0] next_state;
	wire      holdEnabled;

	assign holdEnabled = (holdoverMode == `HOLD_MODE_ENABLED);

	always @* begin
		next_state = state;
		case (state)
			ST_ACQUIRE: begin
				if (next_lock)
					next_state = ST_LOCKED;
			end
			ST_LOCKED: begin
				if (!next_lock) begin
					if (holdEnabled && !lockloss_holdover_disable)
						next_state = ST_HOLDOVER;
					else
						next_state = ST_ACQUIRE;
				end
			end
			ST_HOLDOVER: begin
				if (referenceValid || !holdEnabled)
					next_state = ST_ACQUIRE;
			end
			default: begin
				next_state = ST_ACQUIRE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// holdover dac source
	// ------------------------------------------------------------
	reg [DAC_W-1:0] trackedCode;
	reg [DAC_W-1:0] next_dac;

	always @* begin
		if (manual_dac_enable)
			next_dac = manual_dac_value;
		else
			next_dac = trackedCode;
	end

	// ------------------------------------------------------------
	// holdover entry decode
	// ------------------------------------------------------------
	wire nextHold;

	assign nextHold = (next_state == ST_HOLDOVER);

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_ACQUIRE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// lock counter register
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lockCount <= `LOCK_CNT_ZERO;
		end else begin
			lockCount <= next_lockCount;
		end
	end

	// ------------------------------------------------------------
	// lock indication register
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lock_indication <= 1'b0;
		end else begin
			lock_indication <= next_lock;
		end
	end

	// ------------------------------------------------------------
	// holdover flag register
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			holdoverActive <= 1'b0;
		end else begin
			holdoverActive <= nextHold;
		end
	end

	// ------------------------------------------------------------
	// oscillator hold register
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tuneHold <= 1'b0;
		end else begin
			tuneHold <= nextHold;
		end
	end

	// ------------------------------------------------------------
	// tracked tuning code
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trackedCode <= `DAC_RESET;
		end else begin
			// track only while locked and not in holdover
			if (trackEnable && (state == ST_LOCKED))
				trackedCode <= tuneVoltageCode;
		end
	end

	// ------------------------------------------------------------
	// holdover dac output register
	// ------------------------------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			holdoverDacCode <= `DAC_RESET;
		end else begin
			holdoverDacCode <= next_dac;
		end
	end

endmodule

`default_nettype wire

/* tb/pll_lock_detect_holdover_props.sv */
// port assertions for lock detect and holdover
`default_nettype none
module pll_lock_detect_holdover_props (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [13:0] lock_count_target,
	input wire logic [1:0] holdoverMode,
	input wire logic lockloss_holdover_disable,
	input wire logic trackEnable,
	input wire logic manual_dac_enable,
	input wire logic [9:0] manual_dac_value,
	input wire logic referenceValid,
	input wire logic lock_indication,
	input wire logic holdoverActive,
	input wire logic [9:0] holdoverDacCode,
	input wire logic [13:0] lockCount
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_LOCK: assert property ($rose(lock_indication) |-> lockCount >= lock_count_target)
		else $error("early lock");
	AST_DROP: assert property ($fell(lock_indication) |-> lockCount == 14'h0000)
		else $error("drop kept count");
	AST_ENTER: assert property ($rose(holdoverActive) |->
		$fell(lock_indication) && holdoverMode == 2'h2 && !lockloss_holdover_disable)
		else $error("bad hold entry");
	AST_EXIT: assert property (holdoverActive && referenceValid |=> !holdoverActive)
		else $error("no hold exit");
	AST_MAN: assert property (manual_dac_enable ##1 manual_dac_enable |->
		holdoverDacCode == $past(manual_dac_value))
		else $error("manual code");
	AST_NOTRK: assert property ((!trackEnable && !manual_dac_enable) [*3] |->
		$stable(holdoverDacCode))
		else $error("code tracked");
	AST_IDLE: assert property (holdoverActive |-> !lock_indication && lockCount == 14'h0000)
		else $error("count in hold");
	AST_STEP: assert property (lockCount != $past(lockCount) |->
		lockCount == 14'h0000 || lockCount == $past(lockCount) + 14'h0001)
		else $error("count step");
	COV_LOCK: cover property ($rose(lock_indication));
	COV_HOLD: cover property ($rose(holdoverActive));
	COV_EXIT: cover property ($fell(holdoverActive));
endmodule
bind pll_lock_detect_holdover pll_lock_detect_holdover_props pll_lock_detect_holdover_props_inst (.*);
`default_nettype wire

/* tb/ref_osc_model.sv */
// reference presence and tunable oscillator model
`default_nettype none
module ref_osc_model (
	input wire logic core_clk,
	input wire logic refOn,
	input wire logic tuneHold,
	input wire logic [9:0] holdoverDacCode,
	output var logic referenceValid,
	output var logic [9:0] tuneVoltageCode
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		referenceValid = 1'b0;
		tuneVoltageCode = 10'h0100;
	end
	always @(posedge core_clk) begin
		referenceValid <= refOn;
		// held at the dac code, drifting otherwise
		if (tuneHold)
			tuneVoltageCode <= holdoverDacCode;
		else
			tuneVoltageCode <= tuneVoltageCode + 10'h001;
	end
endmodule
`default_nettype wire

/* tb/pll_lock_detect_holdover_tb.sv */
// bench for lock detect and holdover
`default_nettype none
module pll_lock_detect_holdover_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst = 1, compareStrobe = 0, refOn = 0, trackEnable = 0;
	logic [11:0] phaseError = 0, phase_window_size = 12'h0020;
	logic [13:0] lock_count_target = 14'h0003; // above one
	logic [1:0] holdoverMode = 2'h2;
	logic lockloss_holdover_disable = 0, manual_dac_enable = 1, referenceValid;
	logic [9:0] manual_dac_value = 10'h0200, tuneVoltageCode, holdoverDacCode;
	logic lock_indication, holdoverActive, tuneHold;
	logic [13:0] lockCount;
	int miscompares = 0, check_count = 0, cyc = 0;
	always #4 core_clk = ~core_clk;
	pll_lock_detect_holdover pll_lock_detect_holdover_inst (.*);
	ref_osc_model ref_osc_model_inst (.*);
	task automatic chk(input string nm, input logic [13:0] e, g);
		check_count++;
		if (e !== g) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic strb(input logic [11:0] e);
		@(posedge core_clk) compareStrobe <= 1;
		phaseError <= e;
		@(posedge core_clk) compareStrobe <= 0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic t_lock;
		strb(12'h020);
		strb(12'hFE0);
		chk("lock", 0, lock_indication);
		chk("count", 2, lockCount);
		strb(12'h010);
		chk("lock", 1, lock_indication);
		$display("t_lock done");
	endtask
	task automatic t_hold;
		strb(12'h021);
		chk("lock", 0, lock_indication);
		chk("hold", 1, holdoverActive);
		chk("tuneHold", 1, tuneHold);
		chk("dac", 10'h200, holdoverDacCode);
		chk("tune", 10'h200, tuneVoltageCode);
		@(posedge core_clk) refOn <= 1;
		repeat (2) @(posedge core_clk);
		#1;
		chk("hold", 0, holdoverActive);
		$display("t_hold done");
	endtask
	task automatic t_nohold;
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk) refOn <= 0;
			lockloss_holdover_disable <= !i;
			holdoverMode <= i ? 2'h1 : 2'h2;
			manual_dac_enable <= 0;
			repeat (3) strb(12'h001);
			chk("lock", 1, lock_indication);
			strb(12'h800);
			chk("hold", 0, holdoverActive);
		end
		$display("t_nohold done");
	endtask
	task automatic t_track;
		logic [9:0] frozen;
		@(posedge core_clk) trackEnable <= 1;
		manual_dac_enable <= 0;
		holdoverMode <= 2'h2;
		lockloss_holdover_disable <= 0;
		repeat (3) strb(12'h001);
		repeat (2) @(posedge core_clk);
		#1;
		chk("dac", 10'(tuneVoltageCode - 10'h002), holdoverDacCode);
		@(posedge core_clk) trackEnable <= 0;
		repeat (4) @(posedge core_clk);
		#1;
		frozen = holdoverDacCode;
		repeat (3) @(posedge core_clk);
		#1;
		chk("dac", frozen, holdoverDacCode);
		strb(12'h021);
		chk("hold", 1, holdoverActive);
		chk("tune", frozen, tuneVoltageCode);
		chk("dac", frozen, holdoverDacCode);
		@(posedge core_clk) holdoverMode <= 2'h1;
		@(posedge core_clk);
		#1;
		chk("hold", 0, holdoverActive);
		$display("t_track done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			wrap_up;
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 0;
		t_lock;
		t_hold;
		t_nohold;
		t_track;
		wrap_up;
	end
endmodule
`default_nettype wire
